/* File: pkg/tsf_cfg.svh */
`ifndef TSF_CFG_SVH
`define TSF_CFG_SVH

// ----------------------------------------------------------------
// clocking and rates
// ----------------------------------------------------------------
`define TSF_CLK_HZ      40000000
`define TSF_BIT_RATE_HZ 1000000
`define TSF_HALF_DIV    (`TSF_CLK_HZ / (2 * `TSF_BIT_RATE_HZ))

// ----------------------------------------------------------------
// word and frame layout
// ----------------------------------------------------------------
`define TSF_WORD_BITS   24
`define TSF_MAX_TRACKS  4
`define TSF_SYNC_WORD   24'hfaf320
`define TSF_FILL_INFO   16'haaaa
`define TSF_CRC_POLY    16'h8005
`define TSF_CRC_INIT    16'h0000
`define TSF_FLEN_MIN    9'h081
`define TSF_FLEN_MAX    9'h1ff
`define TSF_FLEN_RST    9'h100
`define TSF_FIFO_DEPTH  16
`define TSF_TIME_WORDS  12'h003

// ----------------------------------------------------------------
// content labels
// ----------------------------------------------------------------
`define TSF_LBL_CMD_A   4'hf
`define TSF_LBL_STS_A   4'he
`define TSF_LBL_DAT_A   4'hd
`define TSF_LBL_ERR_A   4'hc
`define TSF_LBL_CMD_B   4'hb
`define TSF_LBL_STS_B   4'ha
`define TSF_LBL_DAT_B   4'h9
`define TSF_LBL_ERR_B   4'h8
`define TSF_LBL_T_HI    4'h7
`define TSF_LBL_T_LO    4'h6
`define TSF_LBL_T_US    4'h5
`define TSF_LBL_T_RSP   4'h4
`define TSF_LBL_USER0   4'h3
`define TSF_LBL_USER1   4'h2
`define TSF_LBL_FILL    4'h1
`define TSF_LBL_OVF     4'h0
`define TSF_LBL_CRC     4'h3

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define TSF_AXI_AW      8
`define TSF_OFS_CTRL    8'h00
`define TSF_OFS_BUS     8'h04
`define TSF_OFS_FLEN    8'h08
`define TSF_OFS_FCNT    8'h0c
`define TSF_OFS_LOST    8'h10
`define TSF_CTRL_RST    7'h01
`define TSF_BUS_RST     4'h0
`define TSF_CTRL_TK     2:0
`define TSF_CTRL_TIME   3
`define TSF_CTRL_CRC    4
`define TSF_CTRL_BIP    5
`define TSF_CTRL_RUN    6
`define TSF_RESP_OKAY   2'h0
`define TSF_RESP_SLVERR 2'h2

`endif

/* File: pkg/tsf_pkg.sv */
`include "tsf_cfg.svh"

package tsf_pkg;

  typedef enum logic [1:0] {TSF_KIND_CMD, TSF_KIND_STS, TSF_KIND_DAT} tsf_kind_t;

  typedef struct packed {
    logic        aw_hold;
    logic [7:0]  aw_addr;
    logic        w_hold;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [6:0]  ctrl;
    logic [3:0]  bus_id;
    logic [8:0]  flen;
    logic [2:0]  a_tk;
    logic        a_time;
    logic        a_crc;
    logic        a_bip;
    logic [3:0]  a_bus;
    logic [8:0]  a_flen;
    logic [15:0] div;
    logic        half_ph;
    logic [4:0]  phase;
    logic [8:0]  slot;
    logic        started;
    logic [15:0] t_hi;
    logic [15:0] t_lo;
    logic [15:0] t_us;
    logic        ovf_pend;
    logic [15:0] lost;
    logic [15:0] fcnt;
  } tsf_state_t;

  typedef struct packed {
    logic [23:0] sreg;
    logic [15:0] crc;
    logic [14:0] scr;
    logic        in_crc;
    logic        cur;
    logic        line;
  } tsf_ser_t;

endpackage

/* File: logic/tsf_word_fifo.sv */
`timescale 1ns/10ps
module tsf_word_fifo #(
  parameter int W = 20,
  parameter int D = `TSF_FIFO_DEPTH
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
  } tsf_fifo_t;

  tsf_fifo_t s;
  tsf_fifo_t next_s;
  logic      push;
  logic      pop;

  assign in_ready  = s.cnt != (AW+1)'(D);
  assign out_valid = s.cnt != '0;
  assign out_data  = s.mem[s.rp];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    next_s = s;
    if (push) begin
      next_s.mem[s.wp] = in_data;
      next_s.wp = (s.wp == AW'(D-1)) ? '0 : s.wp + 1'b1;
    end
    if (pop) begin
      next_s.rp = (s.rp == AW'(D-1)) ? '0 : s.rp + 1'b1;
    end
    next_s.cnt = s.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule

/* File: logic/tsf_track_ser.sv */
`timescale 1ns/10ps
module tsf_track_ser (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        active,
  input  wire logic        bit_en,
  input  wire logic        half_en,
  input  wire logic        biphase,
  input  wire logic        load,
  input  wire logic        load_sync,
  input  wire logic        load_crc,
  input  wire logic [23:0] load_word,
  output logic             line
);
  import tsf_pkg::*;

  tsf_ser_t    s;
  tsf_ser_t    next_s;
  logic [23:0] w;
  logic        nb;
  logic        rn;
  logic        fb;
  logic [15:0] base;

  assign line = s.line;

  always_comb begin
    next_s = s;
    w    = load_crc ? {load_word[23:16], s.crc} : load_word;
    nb   = load ? w[23] : s.sreg[22];
    rn   = nb ^ s.scr[13] ^ s.scr[14];
    base = (load && load_sync) ? `TSF_CRC_INIT : s.crc;
    fb   = base[15] ^ nb;
    if (!active) begin
      next_s = '0;
    end else if (bit_en) begin
      next_s.sreg = load ? w : {s.sreg[22:0], 1'b0};
      if (load) begin
        next_s.in_crc = load_crc;
      end
      if (!(load ? load_crc : s.in_crc)) begin
        next_s.crc = {base[14:0], 1'b0} ^ (fb ? `TSF_CRC_POLY : '0);
      end
      next_s.scr  = {s.scr[13:0], rn};
      next_s.cur  = nb;
      next_s.line = biphase ? nb : rn;
    end else if (half_en && biphase) begin
      next_s.line = ~s.cur;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule

/* File: logic/tsf_formatter.sv */
// What this block does
// - each track stream is line coded as randomized NRZ-level or bi-phase-level
// - one PCM stream per track, successive streams offset by 24/track_count bits
// - track count is set per monitored bus, at most four tracks
// - every track stream opens each frame with its own 24-bit sync word
// - frame length in words is fixed and equal for all tracks of the bus
// - words are serialized most significant bit first, bit 1 leading
// - optional check word appended to every frame of every track stream
// - four tracks with time: streams 1-3 carry high, low, microsecond time words
// - four tracks with time: stream 4 carries first data word after sync
// - fewer tracks distribute time and data words track by track in rotation
// - without frame time, data words follow the sync word directly
// - the bus side is a passive monitor only, it never transmits
// - formatted word is bus label, content label, 16-bit information field
// - bus word sync pattern and parity bit are stripped, 16 bits kept
// - every captured, auxiliary and time word gets a 4-bit content label
// - bus-word bit 4 lands in formatted bit 9, order kept
// - bus error words labelled 1100 primary, 1000 secondary, info kept
// - sync, Manchester, parity, contiguity and bit-count faults are bus errors
// - bus label bits 1-4 hold bus number minus one
// - time labels 0111-0100, user 0011/0010, fill 0001, overflow 0000
// - input buffering keeps bus data across output slots
// - sync word is FAF320 hex, first word of each frame
// - frame length fixed by fill words, between 129 and 511 words
// - fill words carry information pattern AAAA hex
// - check word holds CRC-16 x16+x15+x2+1 in bits 9-24, last in frame
`timescale 1ns/10ps
module tsf_formatter #(
  parameter int HALF_DIV = `TSF_HALF_DIV,
  parameter int NTRK     = `TSF_MAX_TRACKS,
  parameter int DEPTH    = `TSF_FIFO_DEPTH
) (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  input  wire logic [`TSF_AXI_AW-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [`TSF_AXI_AW-1:0] s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  input  wire logic                   mon_valid,
  input  wire logic [19:0]            mon_word,
  input  wire logic                   mon_chan_b,
  input  wire tsf_pkg::tsf_kind_t     mon_kind,
  input  wire logic                   mon_sync_err,
  input  wire logic                   mon_manch_err,
  input  wire logic                   mon_contig_err,
  input  wire logic                   mon_bitcnt_err,
  input  wire logic                   resp_valid,
  input  wire logic [15:0]            resp_time,
  input  wire logic                   aux_valid,
  input  wire logic                   aux_sel,
  input  wire logic [15:0]            aux_word,
  input  wire logic [15:0]            time_hi,
  input  wire logic [15:0]            time_lo,
  input  wire logic [15:0]            time_us,
  output logic                        rec_clk,
  output logic [NTRK-1:0]             track_line
);
  import tsf_pkg::*;

  tsf_state_t      s;
  tsf_state_t      next_s;
  logic            run;
  logic            half_en;
  logic            bit_en;
  logic [8:0]      ns;
  logic [8:0]      cur_slot;
  logic            fstart;
  logic [NTRK-1:0] ld;
  logic [1:0]      kk;
  logic [11:0]     tidx;
  logic            w_sync;
  logic            w_crc;
  logic [23:0]     w_out;
  logic            f_in_valid;
  logic            f_in_ready;
  logic [19:0]     f_in_data;
  logic            f_out_valid;
  logic            f_out_ready;
  logic [19:0]     f_out_data;
  logic            mon_err;
  logic [3:0]      mon_lbl;
  logic [19:0]     src_data;
  logic            src_any;
  logic            multi;
  logic            lost_ev;
  logic            aw_ok;
  logic            w_ok;
  logic [7:0]      waddr;
  logic [31:0]     wdat;
  logic [31:0]     wmask;
  logic [31:0]     wv;
  logic [6:0]      new_ctrl;
  logic            lost_clr;

  function automatic logic [4:0] tsf_off(input logic [2:0] tk);
    unique case (tk)
      3'h2:    tsf_off = 5'(`TSF_WORD_BITS / 2);
      3'h3:    tsf_off = 5'(`TSF_WORD_BITS / 3);
      3'h4:    tsf_off = 5'(`TSF_WORD_BITS / 4);
      default: tsf_off = 5'(`TSF_WORD_BITS - 1);
    endcase
  endfunction

  // ----------------------------------------------------------------
  // bus handshakes
  // ----------------------------------------------------------------
  assign s_axi_awready = !s.aw_hold && !s.bvalid;
  assign s_axi_wready  = !s.w_hold && !s.bvalid;
  assign s_axi_bvalid  = s.bvalid;
  assign s_axi_bresp   = s.bresp;
  assign s_axi_arready = !s.rvalid;
  assign s_axi_rvalid  = s.rvalid;
  assign s_axi_rdata   = s.rdata;
  assign s_axi_rresp   = s.rresp;

  // ----------------------------------------------------------------
  // bit timing
  // ----------------------------------------------------------------
  assign run     = s.ctrl[`TSF_CTRL_RUN];
  assign half_en = run && (s.div == 16'(HALF_DIV - 1));
  assign bit_en  = half_en && s.half_ph;
  assign rec_clk = s.half_ph;
  assign ns      = (!s.started || s.slot == s.a_flen - 9'h001) ? '0 : s.slot + 9'h001;
  assign cur_slot = (s.phase == '0) ? ns : s.slot;
  assign fstart  = bit_en && s.phase == '0 && ns == '0;

  // ----------------------------------------------------------------
  // monitored bus capture
  // ----------------------------------------------------------------
  always_comb begin
    // receive only: no transmit path exists toward the bus
    mon_err = mon_sync_err || mon_manch_err || mon_contig_err || mon_bitcnt_err
              || !(^mon_word[16:0]);
    unique case (mon_kind)
      TSF_KIND_CMD: mon_lbl = mon_chan_b ? `TSF_LBL_CMD_B : `TSF_LBL_CMD_A;
      TSF_KIND_STS: mon_lbl = mon_chan_b ? `TSF_LBL_STS_B : `TSF_LBL_STS_A;
      default:      mon_lbl = mon_chan_b ? `TSF_LBL_DAT_B : `TSF_LBL_DAT_A;
    endcase
    if (mon_err) begin
      mon_lbl = mon_chan_b ? `TSF_LBL_ERR_B : `TSF_LBL_ERR_A;
    end
    src_any = mon_valid || resp_valid || aux_valid;
    multi   = (mon_valid && (resp_valid || aux_valid)) || (resp_valid && aux_valid);
    if (mon_valid) begin
      src_data = {mon_lbl, mon_word[16:1]};
    end else if (resp_valid) begin
      src_data = {`TSF_LBL_T_RSP, resp_time};
    end else begin
      src_data = {aux_sel ? `TSF_LBL_USER1 : `TSF_LBL_USER0, aux_word};
    end
    f_in_valid = s.ovf_pend || src_any;
    f_in_data  = s.ovf_pend ? {`TSF_LBL_OVF, s.lost} : src_data;
    lost_ev    = (src_any && !(f_in_ready && !s.ovf_pend)) || multi;
  end

  tsf_word_fifo #(
    .W (20),
    .D (DEPTH)
  ) u_fifo (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .in_valid  (f_in_valid),
    .in_ready  (f_in_ready),
    .in_data   (f_in_data),
    .out_valid (f_out_valid),
    .out_ready (f_out_ready),
    .out_data  (f_out_data)
  );

  // ----------------------------------------------------------------
  // word scheduling across tracks
  // ----------------------------------------------------------------
  always_comb begin
    ld = '0;
    kk = '0;
    for (int k = 0; k < NTRK; k++) begin
      if (bit_en && 3'(k) < s.a_tk && s.phase == 5'(k * tsf_off(s.a_tk))) begin
        ld[k] = 1'b1;
        kk    = 2'(k);
      end
    end
    tidx   = 12'((12'(cur_slot) - 12'h001) * 12'(s.a_tk) + 12'(kk));
    w_sync = cur_slot == '0;
    w_crc  = s.a_crc && cur_slot == s.a_flen - 9'h001;
    f_out_ready = 1'b0;
    if (w_sync) begin
      w_out = `TSF_SYNC_WORD;
    end else if (w_crc) begin
      w_out = {s.a_bus, `TSF_LBL_CRC, 16'h0000};
    end else if (s.a_time && tidx < `TSF_TIME_WORDS) begin
      unique case (tidx[1:0])
        2'h0:    w_out = {s.a_bus, `TSF_LBL_T_HI, s.t_hi};
        2'h1:    w_out = {s.a_bus, `TSF_LBL_T_LO, s.t_lo};
        default: w_out = {s.a_bus, `TSF_LBL_T_US, s.t_us};
      endcase
    end else if (f_out_valid) begin
      w_out = {s.a_bus, f_out_data};
      f_out_ready = |ld;
    end else begin
      w_out = {s.a_bus, `TSF_LBL_FILL, `TSF_FILL_INFO};
    end
  end

  genvar g;
  generate
    for (g = 0; g < NTRK; g++) begin : gen_trk
      tsf_track_ser u_ser (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .active    (run && 3'(g) < s.a_tk),
        .bit_en    (bit_en),
        .half_en   (half_en),
        .biphase   (s.a_bip),
        .load      (ld[g]),
        .load_sync (w_sync),
        .load_crc  (w_crc),
        .load_word (w_out),
        .line      (track_line[g])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // register writes and state update
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    aw_ok  = s.aw_hold || s_axi_awvalid;
    w_ok   = s.w_hold || s_axi_wvalid;
    waddr  = s.aw_hold ? s.aw_addr : s_axi_awaddr;
    wdat   = s.w_hold ? s.w_data : s_axi_wdata;
    for (int b = 0; b < 4; b++) begin
      wmask[b*8 +: 8] = {8{s.w_hold ? s.w_strb[b] : s_axi_wstrb[b]}};
    end
    wv       = '0;
    new_ctrl = s.ctrl;
    lost_clr = 1'b0;
    if (s_axi_awready && s_axi_awvalid) begin
      next_s.aw_hold = 1'b1;
      next_s.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wready && s_axi_wvalid) begin
      next_s.w_hold = 1'b1;
      next_s.w_data = s_axi_wdata;
      next_s.w_strb = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    if (!s.bvalid && aw_ok && w_ok) begin
      next_s.aw_hold = 1'b0;
      next_s.w_hold  = 1'b0;
      next_s.bvalid  = 1'b1;
      next_s.bresp   = `TSF_RESP_OKAY;
      unique case (waddr)
        `TSF_OFS_CTRL: begin
          wv       = (32'(s.ctrl) & ~wmask) | (wdat & wmask);
          new_ctrl = wv[6:0];
          if (wv[`TSF_CTRL_TK] == '0) begin
            new_ctrl[`TSF_CTRL_TK] = 3'h1;
          end else if (wv[`TSF_CTRL_TK] > 3'(NTRK)) begin
            new_ctrl[`TSF_CTRL_TK] = 3'(NTRK);
          end
          next_s.ctrl = new_ctrl;
        end
        `TSF_OFS_BUS: begin
          wv = (32'(s.bus_id) & ~wmask) | (wdat & wmask);
          next_s.bus_id = wv[3:0];
        end
        `TSF_OFS_FLEN: begin
          wv = (32'(s.flen) & ~wmask) | (wdat & wmask);
          if (wv >= 32'(`TSF_FLEN_MIN) && wv <= 32'(`TSF_FLEN_MAX)) begin
            next_s.flen = wv[8:0];
          end
        end
        `TSF_OFS_FCNT: begin
        end
        `TSF_OFS_LOST: lost_clr = 1'b1;
        default: next_s.bresp = `TSF_RESP_SLVERR;
      endcase
    end
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
    if (s_axi_arready && s_axi_arvalid) begin
      next_s.rvalid = 1'b1;
      next_s.rresp  = `TSF_RESP_OKAY;
      unique case (s_axi_araddr)
        `TSF_OFS_CTRL: next_s.rdata = 32'(s.ctrl);
        `TSF_OFS_BUS:  next_s.rdata = 32'(s.bus_id);
        `TSF_OFS_FLEN: next_s.rdata = 32'(s.flen);
        `TSF_OFS_FCNT: next_s.rdata = 32'(s.fcnt);
        `TSF_OFS_LOST: next_s.rdata = 32'(s.lost);
        default: begin
          next_s.rdata = '0;
          next_s.rresp = `TSF_RESP_SLVERR;
        end
      endcase
    end
    // overflow bookkeeping, a new loss wins over a clear
    if (lost_clr) begin
      next_s.lost = '0;
    end
    if (s.ovf_pend && f_in_ready) begin
      next_s.ovf_pend = 1'b0;
    end
    if (lost_ev) begin
      next_s.lost     = (lost_clr ? 16'h0000 : s.lost) + 16'h0001;
      next_s.ovf_pend = 1'b1;
    end
    if (!run) begin
      next_s.div     = '0;
      next_s.half_ph = 1'b1;
      next_s.phase   = '0;
      next_s.started = 1'b0;
      next_s.a_tk    = s.ctrl[`TSF_CTRL_TK];
      next_s.a_time  = s.ctrl[`TSF_CTRL_TIME];
      next_s.a_crc   = s.ctrl[`TSF_CTRL_CRC];
      next_s.a_bip   = s.ctrl[`TSF_CTRL_BIP];
      next_s.a_bus   = s.bus_id;
      next_s.a_flen  = s.flen;
    end else begin
      next_s.div = half_en ? '0 : s.div + 16'h0001;
      if (half_en) begin
        next_s.half_ph = ~s.half_ph;
      end
      if (bit_en) begin
        next_s.phase = (s.phase == 5'(`TSF_WORD_BITS - 1)) ? '0 : s.phase + 5'h01;
        if (s.phase == '0) begin
          next_s.slot    = ns;
          next_s.started = 1'b1;
        end
      end
      if (fstart) begin
        // config and time only change on frame boundaries
        next_s.a_tk   = s.ctrl[`TSF_CTRL_TK];
        next_s.a_time = s.ctrl[`TSF_CTRL_TIME];
        next_s.a_crc  = s.ctrl[`TSF_CTRL_CRC];
        next_s.a_bip  = s.ctrl[`TSF_CTRL_BIP];
        next_s.a_bus  = s.bus_id;
        next_s.a_flen = s.flen;
        next_s.t_hi   = time_hi;
        next_s.t_lo   = time_lo;
        next_s.t_us   = time_us;
        next_s.fcnt   = s.fcnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s         <= '0;
      s.ctrl    <= `TSF_CTRL_RST;
      s.bus_id  <= `TSF_BUS_RST;
      s.flen    <= `TSF_FLEN_RST;
      s.a_tk    <= 3'h1;
      s.a_flen  <= `TSF_FLEN_RST;
      s.half_ph <= 1'b1;
    end else begin
      s <= next_s;
    end
  end
endmodule

/* File: verif/tsf_formatter_properties.sv */
`timescale 1ns/10ps
module tsf_formatter_chk (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        rec_clk
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ----------------------------------------
  // bus handshake and bit timing
  // ----------------------------------------
  // bench runs HALF_DIV 4
  sequence s_half_hold;
    $stable(rec_clk) [*3];
  endsequence
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  a_rvalid_clear: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("rvalid stuck");
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  a_bvalid_clear: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("bvalid stuck");
  a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answering");
  a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answering");
  a_half_bit: assert property ($changed(rec_clk) |=> s_half_hold)
    else $error("half bit length wrong");
endmodule
bind tsf_formatter tsf_formatter_chk u_chk (.*);

/* File: verif/tsf_rec_model.sv */
`timescale 1ns/10ps
module tsf_rec_model (
  input  wire logic   aclk,
  input  wire logic   rec_clk,
  input  wire logic   line,
  output logic [23:0] word,
  output logic        bit_tick
);
  logic [1:0] dly = 2'h0;
  logic       prev = 1'b1;
  // sample three clocks after rec_clk falls, in the first half, bi-phase first half is the bit
  always @(posedge aclk) begin
    prev <= rec_clk;
    bit_tick <= 1'b0;
    dly <= {dly[0], prev & ~rec_clk};
    if (dly[1]) begin
      word <= {word[22:0], line};
      bit_tick <= 1'b1;
    end
  end
endmodule

/* File: verif/tsf_formatter_tb.sv */
`timescale 1ns/10ps
module tsf_formatter_tb;
  import tsf_pkg::*;
  localparam logic [3:0] BUS = 4'h5;
  logic        aclk = 1'b0, aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, mon_valid = 1'b0;
  logic        mon_chan_b = 1'b0, aux_valid = 1'b0;
  logic [19:0] mon_word = 20'h0;
  logic [3:0]  errs = 4'h0, track_line;
  tsf_kind_t   mon_kind = TSF_KIND_CMD;
  logic [15:0] aux_word = 16'h0, time_hi = 16'h1357, time_lo = 16'h2468, time_us = 16'h0abc;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        rec_clk, tick;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [23:0] rword, rword1;
  logic        tick1;
  int          n_fail = 0, n_checks = 0;
  always #12.5 aclk = ~aclk;
  tsf_formatter #(.HALF_DIV(4)) uut (.*, .s_axi_wstrb(4'hf), .mon_sync_err(errs[0]),
    .mon_manch_err(errs[1]), .mon_contig_err(errs[2]), .mon_bitcnt_err(errs[3]),
    .resp_valid(1'b0), .resp_time(16'h0000), .aux_sel(1'b0));
  tsf_rec_model rec (.aclk, .rec_clk, .line(track_line[0]), .word(rword), .bit_tick(tick));
  tsf_rec_model rec1 (.aclk, .rec_clk, .line(track_line[1]), .word(rword1), .bit_tick(tick1));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    int i;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    s_axi_bready <= 1'b0;
    if (i == 50) begin
      n_fail++;
      finish_test;
    end
    chk(32'(s_axi_bresp), 32'(e));
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] re);
    int i;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    s_axi_rready <= 1'b0;
    if (i == 50) begin
      n_fail++;
      finish_test;
    end
    chk(s_axi_rdata, e);
    chk(32'(s_axi_rresp), 32'(re));
  endtask
  task automatic wait_word(input logic [23:0] exp, input int t = 0);
    int i;
    for (i = 0; i < 30000 && !((t == 0 ? tick : tick1) === 1'b1
         && (t == 0 ? rword : rword1) === exp); i++) @(posedge aclk);
    chk(32'(t == 0 ? rword : rword1), 32'(exp));
    if (i == 30000) begin
      n_fail++;
      finish_test;
    end
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs;
    rchk(8'h00, 32'h1, 2'h0);
    rchk(8'h08, 32'h100, 2'h0);
    rchk(8'h14, 32'h0, 2'h2);
    wr(8'h14, 32'h5, 2'h2);
    wr(8'h08, 32'h80, 2'h0);
    rchk(8'h08, 32'h100, 2'h0);
    wr(8'h08, 32'h81, 2'h0);
    rchk(8'h08, 32'h81, 2'h0);
    wr(8'h00, 32'h7, 2'h0);
    rchk(8'h00, 32'h4, 2'h0);
    wr(8'h00, 32'h0, 2'h0);
    rchk(8'h00, 32'h1, 2'h0);
    wr(8'h04, 32'h5, 2'h0);
    rchk(8'h04, 32'h5, 2'h0);
  endtask
  task automatic t_stream;
    logic [15:0] inf;
    wr(8'h00, 32'h61, 2'h0);
    wait_word(24'hfaf320);
    wait_word({BUS, 4'h1, 16'haaaa});
    for (int i = 0; i < 8; i++) begin
      inf = 16'h1234 + 16'(i * 16'h0111);
      @(posedge aclk);
      mon_valid <= 1'b1;
      mon_chan_b <= i[2];
      mon_kind <= (i[1:0] == 2'd3) ? TSF_KIND_DAT : tsf_kind_t'(i[1:0]);
      errs <= (i[1:0] == 2'd3) ? 4'h1 << i[2:1] : 4'h0;
      mon_word <= {3'b100, inf, ~^inf};
      @(posedge aclk);
      mon_valid <= 1'b0;
      wait_word({BUS, 4'hf - 4'(i), inf});
    end
    @(posedge aclk);
    aux_valid <= 1'b1;
    aux_word <= 16'h5a0f;
    @(posedge aclk);
    aux_valid <= 1'b0;
    wait_word({BUS, 4'h3, 16'h5a0f});
  endtask
  task automatic t_time;
    wr(8'h00, 32'h6a, 2'h0);
    wait_word(24'hfaf320, 1);
    wait_word({BUS, 4'h7, time_hi});
    wait_word({BUS, 4'h6, time_lo}, 1);
    wait_word({BUS, 4'h5, time_us});
  endtask
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs;
    t_stream;
    t_time;
    finish_test;
  end
endmodule
